// ==== hw/arcf_regs.svh ====
// register map, field positions and reset values of the result compare and filter block
`ifndef ARCF_REGS_SVH
`define ARCF_REGS_SVH

// ----------------------------------------------------------------
// register addresses (word index)
// ----------------------------------------------------------------
`define ARCF_ADDR_W 4
`define ARCF_CMP_BASE 4'h0
`define ARCF_CMP_STRIDE 4'h5
`define ARCF_CMP_CON 4'h0
`define ARCF_CMP_ENL 4'h1
`define ARCF_CMP_ENH 4'h2
`define ARCF_CMP_LO 4'h3
`define ARCF_CMP_HI 4'h4
`define ARCF_FLT_BASE 4'ha
`define ARCF_FLT_STRIDE 4'h2
`define ARCF_FLT_CON 4'h0
`define ARCF_FLT_DAT 4'h1
`define ARCF_IRQ_STAT 4'he
`define ARCF_IRQ_MASK 4'hf

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ARCF_CMP_EVCH_LSB 8
`define ARCF_CMP_EN_BIT 7
`define ARCF_CMP_IRQEN_BIT 6
`define ARCF_CMP_STAT_BIT 5
`define ARCF_FLT_EN_BIT 15
`define ARCF_FLT_MODE_LSB 13
`define ARCF_FLT_RATIO_LSB 10
`define ARCF_FLT_IRQEN_BIT 9
`define ARCF_FLT_RDY_BIT 8

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define ARCF_NUM_CHAN 5'h16
`define ARCF_MODE_OVS 2'h0
`define ARCF_MODE_AVG 2'h3
`define ARCF_SEL_WIN 3'h4
`define ARCF_SEL_GE_HI 3'h3
`define ARCF_SEL_LT_HI 3'h2
`define ARCF_SEL_GE_LO 3'h1
`define ARCF_SEL_LT_LO 3'h0
`define ARCF_RST_16 16'h0000
`define ARCF_RST_4 4'h0

`endif

// ==== hw/arcf_pkg.sv ====
// types of the result compare and filter block
package arcf_pkg;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } arcf_bus_t;

    typedef struct packed {
        logic valid;
        logic [4:0] chan;
        logic [11:0] data;
    } arcf_res_t;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] chan;
        logic en;
        logic irq_en;
        logic stat;
        logic [4:0] sel;
        logic [21:0] chen;
        logic [15:0] lo;
        logic [15:0] hi;
    } arcf_cmp_t;

    typedef struct packed {
        logic en;
        logic [1:0] mode;
        logic [2:0] ratio;
        logic irq_en;
        logic rdy;
        logic [4:0] sel;
        logic [19:0] acc;
        logic [7:0] cnt;
        logic [15:0] dat;
    } arcf_flt_t;

    typedef struct packed {
        arcf_cmp_t [1:0] cmp;
        arcf_flt_t [1:0] flt;
        logic [3:0] istat;
        logic [3:0] imask;
        logic [15:0] rdata;
        logic irq;
    } arcf_state_t;

endpackage

// ==== hw/arcf_top.sv ====
// result compare and filter block: two window comparators, two accumulation filters
//
// Overview of operation
// - on a comparator event store the causing channel number in the event channel field.
// - comparator disabled means no events and its status flag held at zero.
// - comparator interrupt enable lets its events reach the common interrupt.
// - event sets status flag; reading the control register clears it.
// - between select: event when low threshold <= result < high threshold.
// - at-or-above-high select: event when result >= high threshold.
// - below-high select: event when result < high threshold.
// - at-or-above-low select: event when result >= low threshold.
// - below-low select: event when result < low threshold.
// - a 22-bit enable vector picks which channels a comparator examines.
// - filter disabled means idle and its ready flag held at zero.
// - mode 00 oversamples; ratio codes give 2x..256x with 13 to 16 bit results.
// - mode 11 averages over 2x..256x and always gives a 12-bit result.
// - filter interrupt enable lets a ready result reach the common interrupt.
// - ready set on new filter data; reading the data register clears it.
// - 5-bit filter channel select names the accumulated input, 0 to 21.
`timescale 1ns/1ps
`include "arcf_regs.svh"

module arcf_top (
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    // register port
    input wire arcf_pkg::arcf_bus_t I_BUS,
    output logic [15:0] O_RD_DATA,
    // conversion results
    input wire arcf_pkg::arcf_res_t I_RES,
    // common converter interrupt
    output logic O_IRQ
);

    arcf_pkg::arcf_state_t s_reg;
    arcf_pkg::arcf_state_t s_next;
    logic [1:0] ev;
    logic [1:0] fdone;
    logic [1:0][15:0] fres;

    // ----------------------------------------------------------------
    // filter ratio decode
    // ----------------------------------------------------------------
    // log2 of the batch length
    function automatic logic [3:0] batch_log2(input logic [1:0] mode, input logic [2:0] r);
        logic [3:0] l;
        l = 4'h0;
        if (mode == `ARCF_MODE_AVG) begin
            l = 4'({1'b0, r}) + 4'h1;
        end else begin
            l = {1'b0, r[1:0], 1'b0} + 4'h2 - 4'({3'h0, r[2]});
        end
        return l;
    endfunction

    // right shift applied to the batch sum
    function automatic logic [3:0] sum_shift(input logic [1:0] mode, input logic [2:0] r);
        logic [3:0] s;
        s = batch_log2(mode, r);
        if (mode == `ARCF_MODE_OVS) begin
            s = s - 4'({2'h0, r[1:0]}) - 4'h1;
        end
        return s;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [15:0] rv;
        logic [15:0] res;
        logic [4:0] hit;
        logic [19:0] sum;
        logic [7:0] last;
        logic [3:0] a;
        logic ok;
        rv = `ARCF_RST_16;
        res = 16'h0000;
        hit = 5'h00;
        sum = 20'h00000;
        last = 8'h00;
        a = 4'h0;
        ok = 1'b0;
        ev = 2'b00;
        fdone = 2'b00;
        fres = '0;
        s_next = s_reg;
        res = {4'h0, I_RES.data};

        // comparators
        for (int k = 0; k < 2; k++) begin
            a = 4'(`ARCF_CMP_BASE + 4'(k) * `ARCF_CMP_STRIDE);
            if (I_BUS.rd && I_BUS.addr == a + `ARCF_CMP_CON) begin
                rv = {3'h0, s_reg.cmp[k].chan, s_reg.cmp[k].en, s_reg.cmp[k].irq_en,
                      s_reg.cmp[k].stat, s_reg.cmp[k].sel};
                s_next.cmp[k].stat = 1'b0;
            end
            if (I_BUS.rd && I_BUS.addr == a + `ARCF_CMP_ENL) begin
                rv = s_reg.cmp[k].chen[15:0];
            end
            if (I_BUS.rd && I_BUS.addr == a + `ARCF_CMP_ENH) begin
                rv = {10'h000, s_reg.cmp[k].chen[21:16]};
            end
            if (I_BUS.rd && I_BUS.addr == a + `ARCF_CMP_LO) begin
                rv = s_reg.cmp[k].lo;
            end
            if (I_BUS.rd && I_BUS.addr == a + `ARCF_CMP_HI) begin
                rv = s_reg.cmp[k].hi;
            end
            if (I_BUS.wr && I_BUS.addr == a + `ARCF_CMP_CON) begin
                s_next.cmp[k].en = I_BUS.wdata[`ARCF_CMP_EN_BIT];
                s_next.cmp[k].irq_en = I_BUS.wdata[`ARCF_CMP_IRQEN_BIT];
                s_next.cmp[k].sel = I_BUS.wdata[4:0];
            end
            if (I_BUS.wr && I_BUS.addr == a + `ARCF_CMP_ENL) begin
                s_next.cmp[k].chen[15:0] = I_BUS.wdata;
            end
            if (I_BUS.wr && I_BUS.addr == a + `ARCF_CMP_ENH) begin
                s_next.cmp[k].chen[21:16] = I_BUS.wdata[5:0];
            end
            if (I_BUS.wr && I_BUS.addr == a + `ARCF_CMP_LO) begin
                s_next.cmp[k].lo = I_BUS.wdata;
            end
            if (I_BUS.wr && I_BUS.addr == a + `ARCF_CMP_HI) begin
                s_next.cmp[k].hi = I_BUS.wdata;
            end
            ok = I_RES.valid && s_reg.cmp[k].en && I_RES.chan < `ARCF_NUM_CHAN;
            ok = ok && s_reg.cmp[k].chen[I_RES.chan];
            hit[`ARCF_SEL_WIN] = res >= s_reg.cmp[k].lo && res < s_reg.cmp[k].hi;
            hit[`ARCF_SEL_GE_HI] = res >= s_reg.cmp[k].hi;
            hit[`ARCF_SEL_LT_HI] = res < s_reg.cmp[k].hi;
            hit[`ARCF_SEL_GE_LO] = res >= s_reg.cmp[k].lo;
            hit[`ARCF_SEL_LT_LO] = res < s_reg.cmp[k].lo;
            ev[k] = ok && |(hit & s_reg.cmp[k].sel);
            if (ev[k]) begin
                s_next.cmp[k].stat = 1'b1;
                s_next.cmp[k].chan = I_RES.chan;
            end
            if (!s_next.cmp[k].en) begin
                s_next.cmp[k].stat = 1'b0;
            end
        end

        // filters
        for (int k = 0; k < 2; k++) begin
            a = 4'(`ARCF_FLT_BASE + 4'(k) * `ARCF_FLT_STRIDE);
            if (I_BUS.rd && I_BUS.addr == a + `ARCF_FLT_CON) begin
                rv = {s_reg.flt[k].en, s_reg.flt[k].mode, s_reg.flt[k].ratio,
                      s_reg.flt[k].irq_en, s_reg.flt[k].rdy, 3'h0, s_reg.flt[k].sel};
            end
            if (I_BUS.rd && I_BUS.addr == a + `ARCF_FLT_DAT) begin
                rv = s_reg.flt[k].dat;
                s_next.flt[k].rdy = 1'b0;
            end
            // any new setting restarts the batch
            if (I_BUS.wr && I_BUS.addr == a + `ARCF_FLT_CON) begin
                s_next.flt[k].en = I_BUS.wdata[`ARCF_FLT_EN_BIT];
                s_next.flt[k].mode = I_BUS.wdata[`ARCF_FLT_MODE_LSB +: 2];
                s_next.flt[k].ratio = I_BUS.wdata[`ARCF_FLT_RATIO_LSB +: 3];
                s_next.flt[k].irq_en = I_BUS.wdata[`ARCF_FLT_IRQEN_BIT];
                s_next.flt[k].sel = I_BUS.wdata[4:0];
                s_next.flt[k].acc = 20'h00000;
                s_next.flt[k].cnt = 8'h00;
            end else if (s_reg.flt[k].en && I_RES.valid && I_RES.chan == s_reg.flt[k].sel
                         && I_RES.chan < `ARCF_NUM_CHAN
                         && (s_reg.flt[k].mode == `ARCF_MODE_OVS
                             || s_reg.flt[k].mode == `ARCF_MODE_AVG)) begin
                sum = s_reg.flt[k].acc + {8'h00, I_RES.data};
                last = 8'((9'h001 << batch_log2(s_reg.flt[k].mode, s_reg.flt[k].ratio))
                          - 9'h001);
                if (s_reg.flt[k].cnt == last) begin
                    fres[k] = 16'(sum >> sum_shift(s_reg.flt[k].mode, s_reg.flt[k].ratio));
                    fdone[k] = 1'b1;
                    s_next.flt[k].dat = fres[k];
                    s_next.flt[k].rdy = 1'b1;
                    s_next.flt[k].acc = 20'h00000;
                    s_next.flt[k].cnt = 8'h00;
                end else begin
                    s_next.flt[k].acc = sum;
                    s_next.flt[k].cnt = s_reg.flt[k].cnt + 8'h01;
                end
            end
            if (!s_next.flt[k].en) begin
                s_next.flt[k].rdy = 1'b0;
                s_next.flt[k].acc = 20'h00000;
                s_next.flt[k].cnt = 8'h00;
            end
        end

        // interrupt status and mask
        if (I_BUS.rd && I_BUS.addr == `ARCF_IRQ_STAT) begin
            rv = {12'h000, s_reg.istat};
        end
        if (I_BUS.rd && I_BUS.addr == `ARCF_IRQ_MASK) begin
            rv = {12'h000, s_reg.imask};
        end
        if (I_BUS.wr && I_BUS.addr == `ARCF_IRQ_STAT) begin
            s_next.istat = s_reg.istat & ~I_BUS.wdata[3:0];
        end
        if (I_BUS.wr && I_BUS.addr == `ARCF_IRQ_MASK) begin
            s_next.imask = I_BUS.wdata[3:0];
        end
        // set wins over the write-one clear
        s_next.istat[0] = s_next.istat[0] | (ev[0] & s_reg.cmp[0].irq_en);
        s_next.istat[1] = s_next.istat[1] | (ev[1] & s_reg.cmp[1].irq_en);
        s_next.istat[2] = s_next.istat[2] | (fdone[0] & s_reg.flt[0].irq_en);
        s_next.istat[3] = s_next.istat[3] | (fdone[1] & s_reg.flt[1].irq_en);
        s_next.irq = |(s_next.istat & s_next.imask);
        s_next.rdata = I_BUS.rd ? rv : `ARCF_RST_16;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign O_RD_DATA = s_reg.rdata;
    assign O_IRQ = s_reg.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_N);

    chan_capture_a: assert property (
        ev[0] |=> (s_reg.cmp[0].stat || !s_reg.cmp[0].en)
        && s_reg.cmp[0].chan == $past(I_RES.chan))
        else $error("event channel not captured");

    cmp_off_a: assert property (
        !s_reg.cmp[0].en |-> !s_reg.cmp[0].stat && !ev[0])
        else $error("disabled comparator shows status");

    cmp_irq_a: assert property (
        $rose(s_reg.istat[0]) |-> $past(ev[0]) && $past(s_reg.cmp[0].irq_en))
        else $error("comparator interrupt bit without cause");

    stat_rdclr_a: assert property (
        I_BUS.rd && I_BUS.addr == `ARCF_CMP_CON && !ev[0] |=> !s_reg.cmp[0].stat)
        else $error("status not cleared by read");

    window_evt_a: assert property (
        I_RES.valid && s_reg.cmp[0].en && s_reg.cmp[0].chen[I_RES.chan]
        && I_RES.chan < `ARCF_NUM_CHAN && s_reg.cmp[0].sel == 5'h10
        && {4'h0, I_RES.data} >= s_reg.cmp[0].lo && {4'h0, I_RES.data} < s_reg.cmp[0].hi
        |=> s_reg.cmp[0].stat || !s_reg.cmp[0].en)
        else $error("window event missed");

    ge_high_evt_a: assert property (
        I_RES.valid && s_reg.cmp[0].en && s_reg.cmp[0].chen[I_RES.chan]
        && I_RES.chan < `ARCF_NUM_CHAN && s_reg.cmp[0].sel == 5'h08
        |-> ev[0] == ({4'h0, I_RES.data} >= s_reg.cmp[0].hi))
        else $error("high threshold event wrong");

    lt_low_evt_a: assert property (
        I_RES.valid && s_reg.cmp[0].en && s_reg.cmp[0].chen[I_RES.chan]
        && I_RES.chan < `ARCF_NUM_CHAN && s_reg.cmp[0].sel == 5'h01
        |-> ev[0] == ({4'h0, I_RES.data} < s_reg.cmp[0].lo))
        else $error("low threshold event wrong");

    chan_gate_a: assert property (
        I_RES.valid && !s_reg.cmp[1].chen[I_RES.chan] |-> !ev[1])
        else $error("disabled channel examined");

    flt_off_a: assert property (
        !s_reg.flt[0].en |-> !s_reg.flt[0].rdy && s_reg.flt[0].cnt == 8'h00)
        else $error("disabled filter shows ready");

    avg_width_a: assert property (
        fdone[0] && s_reg.flt[0].mode == `ARCF_MODE_AVG |=> s_reg.flt[0].dat[15:12] == 4'h0)
        else $error("average wider than 12 bits");

    batch_end_a: assert property (
        fdone[0] |=> s_reg.flt[0].rdy && s_reg.flt[0].cnt == 8'h00
        && s_reg.flt[0].dat == $past(fres[0]))
        else $error("batch end not taken");

    flt_irq_a: assert property (
        fdone[0] && s_reg.flt[0].irq_en |=> s_reg.istat[2] && (O_IRQ || !s_reg.imask[2]))
        else $error("filter interrupt bit not set");

    rdy_rdclr_a: assert property (
        I_BUS.rd && I_BUS.addr == `ARCF_FLT_BASE + `ARCF_FLT_DAT && !fdone[0]
        |=> !s_reg.flt[0].rdy)
        else $error("ready not cleared by data read");

    chan_capture1_a: assert property (
        ev[1] |=> s_reg.cmp[1].chan == $past(I_RES.chan))
        else $error("second comparator channel not captured");

    cmp1_off_a: assert property (
        !s_reg.cmp[1].en |-> !s_reg.cmp[1].stat && !ev[1])
        else $error("disabled second comparator shows status");

    stat_set_a: assert property (
        ev[1] |=> s_reg.cmp[1].stat || !s_reg.cmp[1].en)
        else $error("event did not set status");

    lt_high_evt_a: assert property (
        I_RES.valid && s_reg.cmp[0].en && s_reg.cmp[0].chen[I_RES.chan]
        && I_RES.chan < `ARCF_NUM_CHAN && s_reg.cmp[0].sel == 5'h04
        |-> ev[0] == ({4'h0, I_RES.data} < s_reg.cmp[0].hi))
        else $error("below high event wrong");

    ge_low_evt_a: assert property (
        I_RES.valid && s_reg.cmp[0].en && s_reg.cmp[0].chen[I_RES.chan]
        && I_RES.chan < `ARCF_NUM_CHAN && s_reg.cmp[0].sel == 5'h02
        |-> ev[0] == ({4'h0, I_RES.data} >= s_reg.cmp[0].lo))
        else $error("at or above low event wrong");

    flt1_off_a: assert property (
        !s_reg.flt[1].en |-> !s_reg.flt[1].rdy && s_reg.flt[1].cnt == 8'h00)
        else $error("disabled second filter shows ready");

    ovs_width_a: assert property (
        fdone[0] && s_reg.flt[0].mode == `ARCF_MODE_OVS && s_reg.flt[0].ratio[1:0] == 2'h0
        |=> s_reg.flt[0].dat[15:13] == 3'h0)
        else $error("oversampled result wider than 13 bits");

    irq_level_a: assert property (
        O_IRQ == |(s_reg.istat & s_reg.imask))
        else $error("interrupt output disagrees with status");

    rdy_set_a: assert property (
        fdone[1] |=> s_reg.flt[1].rdy)
        else $error("second filter ready not set");

    flt_chan_a: assert property (
        I_RES.valid && I_RES.chan != s_reg.flt[0].sel
        && !(I_BUS.wr && I_BUS.addr == `ARCF_FLT_BASE)
        |=> s_reg.flt[0].cnt == $past(s_reg.flt[0].cnt))
        else $error("filter counted another channel");

endmodule

// ==== dv/arcf_conv_model.sv ====
// behavioural model of the conversion cores that deliver per-channel results
`timescale 1ns/1ps

module arcf_conv_model (
    // clock
    input wire logic i_clk,
    // pacing: one idle cycle after each result when high
    input wire logic i_slow,
    // result stream towards the block
    output arcf_pkg::arcf_res_t o_res
);
    logic [16:0] pend_q [$];
    logic gap_reg;

    initial begin
        o_res = '0;
        gap_reg = 1'b0;
    end

    task automatic push(input logic [4:0] ch, input logic [11:0] d);
        pend_q.push_back({ch, d});
    endtask

    function automatic int pending();
        return pend_q.size();
    endfunction

    // ----------------------------------------------------------------
    // one result per cycle at most; idle lines toggle so stale data never looks valid
    // ----------------------------------------------------------------
    always @(posedge i_clk) begin
        if (pend_q.size() > 0 && !gap_reg) begin
            o_res <= {1'b1, pend_q.pop_front()};
            gap_reg <= i_slow;
        end else begin
            o_res <= {1'b0, ~o_res.chan, ~o_res.data};
            gap_reg <= 1'b0;
        end
    end
endmodule

// ==== dv/arcf_tb_top.sv ====
// self-checking bench for the result compare and filter block
`timescale 1ns/1ps
`include "arcf_regs.svh"

module arcf_tb_top;
    logic clk;
    logic rst_n;
    logic slow;
    logic irq;
    logic [15:0] rdata;
    arcf_pkg::arcf_bus_t bus;
    arcf_pkg::arcf_res_t res;
    int bad_count;
    int n_checks;
    logic [4:0] last_ch [2];
    int vals [4] = '{99, 100, 199, 200};

    arcf_top dut_u (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_BUS(bus), .O_RD_DATA(rdata),
        .I_RES(res), .O_IRQ(irq));
    arcf_conv_model conv_u (.i_clk(clk), .i_slow(slow), .o_res(res));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask

    task automatic flush;
        while (conv_u.pending() > 0) @(posedge clk);
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    function automatic logic hit(input logic [4:0] s, input int v);
        return (s[4] && v >= 100 && v < 200)
            || (s[3] && v >= 200)
            || (s[2] && v < 200)
            || (s[1] && v >= 100)
            || (s[0] && v < 100);
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        bad_count++;
        end_sim;
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic [3:0] cb, fb;
        logic [4:0] ch, sel, fch;
        logic e, irq_en;
        logic [15:0] ctl;
        int n, lg, sh, d;
        rst_n = 1'b0;
        bus = '0;
        slow = 1'b0;
        bad_count = 0;
        n_checks = 0;
        last_ch = '{default: 5'h00};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) rd_chk(4'(a), 16'h0000);
        wr(`ARCF_CMP_ENH, 16'hffff);
        rd_chk(`ARCF_CMP_ENH, 16'h003f);
        @(negedge clk);
        check(rdata, 16'h0000);
        wr(`ARCF_CMP_CON, 16'hffff);
        rd_chk(`ARCF_CMP_CON, 16'h00df);
        wr(`ARCF_FLT_BASE, 16'hffff);
        rd_chk(`ARCF_FLT_BASE, 16'hfe1f);
        wr(`ARCF_IRQ_MASK, 16'hffff);
        rd_chk(`ARCF_IRQ_MASK, 16'h000f);
        wr(`ARCF_IRQ_MASK, 16'h0000);
        $display("test reset done");
        for (int c = 0; c < 2; c++) begin
            cb = 4'(5 * c);
            wr(cb + 4'h1, c ? 16'h8000 : 16'h0000);
            wr(cb + 4'h2, c ? 16'h0000 : 16'h0020);
            wr(cb + 4'h3, 16'h0064);
            wr(cb + 4'h4, 16'h00c8);
            slow <= c[0];
            ch = c ? 5'd15 : 5'd21;
            for (int s = 0; s < 5; s++) begin
                for (int i = 0; i < 4; i++) begin
                    sel = 5'(1 << s);
                    wr(cb, {8'h00, 3'b110, sel});
                    conv_u.push(5'd14, 12'h063);
                    conv_u.push(5'd22, 12'h063);
                    conv_u.push(ch, 12'(vals[i]));
                    flush;
                    e = hit(sel, vals[i]);
                    if (e) last_ch[c] = ch;
                    rd_chk(cb, {3'h0, last_ch[c], 2'b11, e, sel});
                    rd_chk(cb, {3'h0, last_ch[c], 2'b11, 1'b0, sel});
                end
            end
        end
        $display("test compare done");
        wr(4'h5, 16'h0000);
        wr(`ARCF_IRQ_STAT, 16'h000f);
        wr(`ARCF_IRQ_MASK, 16'h0001);
        wr(`ARCF_CMP_CON, 16'h00c8);
        conv_u.push(5'd21, 12'h0c8);
        flush;
        check({15'h0, irq}, 16'h0001);
        rd_chk(`ARCF_IRQ_STAT, 16'h0001);
        wr(`ARCF_IRQ_STAT, 16'h0001);
        repeat (2) @(negedge clk);
        check({15'h0, irq}, 16'h0000);
        wr(`ARCF_IRQ_MASK, 16'h0000);
        conv_u.push(5'd21, 12'h0c8);
        flush;
        check({15'h0, irq}, 16'h0000);
        rd_chk(`ARCF_IRQ_STAT, 16'h0001);
        wr(`ARCF_IRQ_STAT, 16'h0001);
        wr(`ARCF_CMP_CON, 16'h0088);
        conv_u.push(5'd21, 12'h0c8);
        flush;
        rd_chk(`ARCF_IRQ_STAT, 16'h0000);
        wr(`ARCF_CMP_CON, 16'h0008);
        rd_chk(`ARCF_CMP_CON, 16'h1508);
        conv_u.push(5'd21, 12'h0c8);
        flush;
        rd_chk(`ARCF_CMP_CON, 16'h1508);
        $display("test interrupt done");
        wr(`ARCF_IRQ_MASK, 16'h000f);
        for (int f = 0; f < 2; f++) begin
            fb = 4'(10 + 2 * f);
            fch = f ? 5'd3 : 5'd21;
            slow <= f[0];
            for (int m = 0; m < 4; m += 3) begin
                for (int code = 0; code < 8; code++) begin
                    irq_en = code[0];
                    lg = (m == 3) ? code + 1 : (code < 4 ? 2 + 2 * code : 1 + 2 * (code - 4));
                    n = 1 << lg;
                    sh = (m == 3) ? lg : lg - ((code & 3) + 1);
                    d = 12'hffe - code * 12'h211;
                    ctl = {1'b1, 2'(m), 3'(code), irq_en, 1'b0, 3'h0, fch};
                    wr(fb, ctl);
                    conv_u.push(5'd7, 12'hfff);
                    for (int k = 0; k < n - 1; k++) conv_u.push(fch, 12'(d + k % 2));
                    flush;
                    rd_chk(fb, ctl);
                    conv_u.push(fch, 12'(d + 1));
                    flush;
                    rd_chk(fb, ctl | 16'h0100);
                    check({15'h0, irq}, {15'h0, irq_en});
                    rd_chk(fb + 4'h1, 16'((n * d + n / 2) >> sh));
                    rd_chk(fb, ctl);
                    rd_chk(`ARCF_IRQ_STAT, 16'(irq_en) << (2 + f));
                    wr(`ARCF_IRQ_STAT, 16'h000f);
                end
            end
            wr(fb, {11'h700, fch});
            conv_u.push(fch, 12'h001);
            conv_u.push(fch, 12'h003);
            flush;
            wr(fb, {11'h300, fch});
            rd_chk(fb, {11'h300, fch});
            conv_u.push(fch, 12'h001);
            conv_u.push(fch, 12'h003);
            flush;
            rd_chk(fb, {11'h300, fch});
            wr(fb, {11'h500, fch});
            conv_u.push(fch, 12'h001);
            conv_u.push(fch, 12'h003);
            flush;
            rd_chk(fb, {11'h500, fch});
        end
        $display("test filter done");
        end_sim;
    end
endmodule
